// ==== common/fcrc_map.svh ====
// register offsets, field positions and reset values of the flash rewrite control block
`ifndef FCRC_MAP_SVH
`define FCRC_MAP_SVH
`define FCRC_OFS_CTRL       4'h0
`define FCRC_OFS_STATUS     4'h1
`define FCRC_OFS_PROC_MODE  4'h2
`define FCRC_OFS_ID_KEY     4'h3
`define FCRC_BIT_ENABLE     0
`define FCRC_BIT_SELECT     1
`define FCRC_BIT_OPTION     2
`define FCRC_BIT_CMD_GO     3
`define FCRC_CMD_LSB        4
`define FCRC_BIT_READY      0
`define FCRC_BIT_PROG_ERR   1
`define FCRC_BIT_ERASE_ERR  2
`define FCRC_BIT_ID_OK      3
`define FCRC_BIT_EXPAND     0
`define FCRC_BIT_DF_ENABLE  1
`define FCRC_BIT_EXPAND_EFF 2
`define FCRC_BIT_DF_EFF     3
`define FCRC_CTRL_RESET     32'h00000000
`define FCRC_PROC_RESET     32'h00000000
// id key default: the value is arbitrary
`define FCRC_ID_DEFAULT     32'h5A5A0001
`endif

// ==== common/fcrc_pkg.sv ====
// types of the flash rewrite control block
package fcrc_pkg;
    typedef enum logic [2:0] {
        FCRC_CMD_NONE   = 3'h0,
        FCRC_CMD_PROG   = 3'h1,
        FCRC_CMD_ERASE  = 3'h2,
        FCRC_CMD_LOCKP  = 3'h3,
        FCRC_CMD_LOCKRD = 3'h4,
        FCRC_CMD_BLANK  = 3'h5
    } fcrc_cmd_t;
    typedef enum logic [2:0] {
        FCRC_IDLE = 3'b001,
        FCRC_START = 3'b010,
        FCRC_BUSY = 3'b100
    } fcrc_state_t;
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } fcrc_av_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } fcrc_av_rsp_t;
    typedef struct packed {
        fcrc_state_t state;
        logic        enable;
        logic        select;
        logic        option;
        fcrc_cmd_t   cmd;
        logic        prog_err;
        logic        erase_err;
        logic        expand_sw;
        logic        df_sw;
        logic        expand_pend;
        logic        pend_valid;
        logic        id_ok;
        logic        ack;
        logic [31:0] rdata;
        logic        start;
    } fcrc_state_s_t;
endpackage

// ==== rtl/fcrc_ctrl.sv ====
// flash cpu rewrite control: ready flag, error flags, map forcing, id check
//
// Contract
// RULE1 - ready reads 0 while a command runs
// RULE2 - ready returns 1 when operation ends
// RULE3 - software issues no command while busy
// RULE4 - no program/erase/blank while error set
// RULE5 - full status check after each command
// RULE6 - no commands in slow or low-current read
// RULE7 - no clock change while busy; fast clocks
// RULE8 - force expansion bit while rewrite enabled
// RULE9 - expansion write during rewrite held until exit
// RULE10 - force data flash enable in rewrite mode
// RULE11 - run rewrite code outside expanded window
// RULE12 - change mode bits with nmi disabled, high
// RULE13 - change option bit only while ready
// RULE14 - slow clock and wait state before entry
// RULE15 - ram-executed mode: no dma from flash
// RULE16 - rom-executed mode: no dma while busy
// RULE17 - clear rewrite enable before wait
// RULE18 - stop: clear enable, disable dma, stop
// RULE19 - data flash wait state at high clock
// RULE20 - option byte written with program image
// RULE21 - rom-executed mode: keep control block intact
// RULE22 - no nmi or address-match during risky ops
// RULE23 - id code check always performed
`timescale 1ns/1ps
`include "fcrc_map.svh"
module fcrc_ctrl
    import fcrc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire fcrc_av_req_t av_req,
    output fcrc_av_rsp_t      av_rsp,
    output logic              flash_ready_flag,
    output logic              internal_area_expansion,
    output logic              data_flash_area_enable,
    output logic              flash_op_start,
    output fcrc_cmd_t         flash_op_cmd,
    input  wire logic         flash_op_done,
    input  wire logic         flash_op_error,
    input  wire logic [31:0]  debug_id_code,
    output logic              debug_access_granted
);

    fcrc_state_s_t q, d;
    logic done_s1, done_s2, err_s1, err_s2;

    // ================================================================
    // status inputs from the flash macro cross in via two flops
    always_ff @(posedge clk) begin
        if (reset) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            err_s1  <= 1'b0;
            err_s2  <= 1'b0;
        end else begin
            done_s1 <= flash_op_done;
            done_s2 <= done_s1;
            err_s1  <= flash_op_error;
            err_s2  <= err_s1;
        end
    end

    function automatic logic is_cmd(input logic [2:0] c);
        return (c >= 3'h1) && (c <= 3'h5);
    endfunction

    // ================================================================
    // next state
    always_comb begin
        logic wr, rd, hit_ctrl;
        d = q;
        wr = av_req.write && !q.ack;
        rd = av_req.read && !q.ack;
        hit_ctrl = wr && (av_req.address == `FCRC_OFS_CTRL);
        d.ack = (av_req.read || av_req.write) && !q.ack;
        d.start = 1'b0;
        if (rd) begin
            case (av_req.address)
                `FCRC_OFS_CTRL: d.rdata = {25'h0, q.cmd, 1'b0, q.option, q.select, q.enable};
                `FCRC_OFS_STATUS: d.rdata = {28'h0, q.id_ok, q.erase_err, q.prog_err,
                                             q.state == FCRC_IDLE};
                `FCRC_OFS_PROC_MODE: d.rdata = {28'h0, q.enable | q.df_sw, q.enable | q.expand_sw,
                                                q.df_sw, q.pend_valid ? q.expand_pend : q.expand_sw};
                default: d.rdata = 32'h0;
            endcase
        end
        if (hit_ctrl) begin
            d.enable = av_req.writedata[`FCRC_BIT_ENABLE];
            d.select = av_req.writedata[`FCRC_BIT_SELECT];
            if (q.state == FCRC_IDLE)
                d.option = av_req.writedata[`FCRC_BIT_OPTION];
        end
        // a held expansion write lands when rewrite mode is left [RULE9]
        if (q.enable && !d.enable && q.pend_valid) begin
            d.expand_sw = q.expand_pend;
            d.pend_valid = 1'b0;
        end
        if (wr && av_req.address == `FCRC_OFS_PROC_MODE) begin
            d.df_sw = av_req.writedata[`FCRC_BIT_DF_ENABLE];
            if (q.enable && d.enable) begin
                d.expand_pend = av_req.writedata[`FCRC_BIT_EXPAND]; // [RULE9]
                d.pend_valid = 1'b1;
            end else begin
                d.expand_sw = av_req.writedata[`FCRC_BIT_EXPAND];
            end
        end
        // writing 1 to an error bit in status clears it
        if (wr && av_req.address == `FCRC_OFS_STATUS) begin
            if (av_req.writedata[`FCRC_BIT_PROG_ERR])
                d.prog_err = 1'b0;
            if (av_req.writedata[`FCRC_BIT_ERASE_ERR])
                d.erase_err = 1'b0;
        end
        // id key compared on every write; no way to bypass it [RULE23]
        if (wr && av_req.address == `FCRC_OFS_ID_KEY)
            d.id_ok = (av_req.writedata == debug_id_code);
        case (q.state)
            FCRC_IDLE: begin
                // busy only starts with rewrite mode enabled and a valid command
                if (hit_ctrl && av_req.writedata[`FCRC_BIT_CMD_GO] && q.enable &&
                    is_cmd(av_req.writedata[`FCRC_CMD_LSB +: 3])) begin
                    d.cmd = fcrc_cmd_t'(av_req.writedata[`FCRC_CMD_LSB +: 3]);
                    d.state = FCRC_START; // [RULE1]
                    d.start = 1'b1;
                end
            end
            FCRC_START: begin
                if (!done_s2)
                    d.state = FCRC_BUSY;
            end
            FCRC_BUSY: begin
                if (done_s2) begin
                    d.state = FCRC_IDLE; // [RULE2]
                    // error bit chosen by command; set wins over clear
                    if (err_s2 && q.cmd == FCRC_CMD_ERASE)
                        d.erase_err = 1'b1;
                    else if (err_s2)
                        d.prog_err = 1'b1;
                end
            end
            default: d.state = FCRC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '{state: FCRC_IDLE, cmd: FCRC_CMD_NONE, default: '0};
        end else begin
            q <= d;
        end
    end

    // ================================================================
    // outputs, each from a flop
    logic ready_q, expand_q, df_q, grant_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            ready_q  <= 1'b1;
            expand_q <= 1'b0;
            df_q     <= 1'b0;
            grant_q  <= 1'b0;
        end else begin
            ready_q  <= (d.state == FCRC_IDLE); // [RULE1]
            expand_q <= d.enable | d.expand_sw; // [RULE8]
            df_q     <= d.enable | d.df_sw; // [RULE10]
            grant_q  <= d.id_ok; // [RULE23]
        end
    end

    assign flash_ready_flag        = ready_q;
    assign internal_area_expansion = expand_q;
    assign data_flash_area_enable  = df_q;
    assign debug_access_granted    = grant_q;
    assign flash_op_start          = q.start;
    assign flash_op_cmd            = q.cmd;
    assign av_rsp.readdata         = q.rdata;
    assign av_rsp.waitrequest      = !q.ack;

    // ================================================================
    // checks
    property p_busy_after_start;
        @(posedge clk) disable iff (reset) q.start |=> !flash_ready_flag;
    endproperty
    a_busy_after_start: assert property (p_busy_after_start) else $error("not busy after start"); // [RULE1]

    property p_ready_after_done;
        @(posedge clk) disable iff (reset) (q.state == FCRC_BUSY && done_s2) |=> flash_ready_flag;
    endproperty
    a_ready_after_done: assert property (p_ready_after_done) else $error("ready not restored"); // [RULE2]

    property p_expand_forced;
        @(posedge clk) disable iff (reset) q.enable |-> internal_area_expansion;
    endproperty
    a_expand_forced: assert property (p_expand_forced) else $error("expansion not forced"); // [RULE8]

    property p_expand_held;
        @(posedge clk) disable iff (reset) (q.enable && d.enable) |=> $stable(q.expand_sw);
    endproperty
    a_expand_held: assert property (p_expand_held) else $error("expansion changed in rewrite mode"); // [RULE9]

    property p_df_forced;
        @(posedge clk) disable iff (reset) q.enable |-> data_flash_area_enable;
    endproperty
    a_df_forced: assert property (p_df_forced) else $error("data flash enable not forced"); // [RULE10]

    property p_grant_needs_id;
        @(posedge clk) disable iff (reset) debug_access_granted |-> q.id_ok;
    endproperty
    a_grant_needs_id: assert property (p_grant_needs_id) else $error("access without id"); // [RULE23]
endmodule

// ==== tb/fcrc_ctrl_test.sv ====
// self-checking testbench of the flash rewrite control block
`timescale 1ns/1ps
`include "fcrc_map.svh"
module fcrc_ctrl_test
    import fcrc_pkg::*;
;
    // ==========================================
    // signals
    localparam logic [31:0] ID_VAL = 32'h1234ABCD; // arbitrary id value
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    fcrc_av_req_t av_req = '0;
    fcrc_av_rsp_t av_rsp;
    logic         flash_ready_flag;
    logic         internal_area_expansion;
    logic         data_flash_area_enable;
    logic         flash_op_start;
    fcrc_cmd_t    flash_op_cmd;
    logic         flash_op_done = 1'b0;
    logic         flash_op_error = 1'b0;
    logic         debug_access_granted;
    int           miscompares = 0;
    int           n_compared = 0;
    int           n_starts = 0;
    fcrc_cmd_t    cap_cmd = FCRC_CMD_NONE;
    logic [31:0]  rd;
    always #4 clk = ~clk;
    fcrc_ctrl uut (
        .clk                     (clk),
        .reset                   (reset),
        .av_req                  (av_req),
        .av_rsp                  (av_rsp),
        .flash_ready_flag        (flash_ready_flag),
        .internal_area_expansion (internal_area_expansion),
        .data_flash_area_enable  (data_flash_area_enable),
        .flash_op_start          (flash_op_start),
        .flash_op_cmd            (flash_op_cmd),
        .flash_op_done           (flash_op_done),
        .flash_op_error          (flash_op_error),
        .debug_id_code           (ID_VAL),
        .debug_access_granted    (debug_access_granted)
    );
    // start is a one-cycle pulse, so it is caught here rather than polled
    always @(posedge clk) begin
        if (flash_op_start === 1'b1) begin
            n_starts <= n_starts + 1;
            cap_cmd  <= flash_op_cmd;
        end
    end
    // ==========================================
    // helpers
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low, released at that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        av_req.address   <= a;
        av_req.writedata <= d;
        av_req.read      <= !wr;
        av_req.write     <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 50);
        q = av_rsp.readdata;
        av_req.read  <= 1'b0;
        av_req.write <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        settle();
        chk({flash_ready_flag, internal_area_expansion, data_flash_area_enable, debug_access_granted}, 4'h8);
        bus(1'b0, `FCRC_OFS_STATUS, 32'h0, rd);
        chk(rd, 32'h00000001);
        bus(1'b0, 4'h9, 32'h0, rd);
        chk(rd, 32'h00000000);
    endtask
    task automatic t_map();
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000001, rd);
        settle();
        chk({internal_area_expansion, data_flash_area_enable}, 2'h3);
        bus(1'b1, `FCRC_OFS_PROC_MODE, 32'h00000001, rd);
        settle();
        chk(internal_area_expansion, 1'b1);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000000, rd);
        settle();
        chk({internal_area_expansion, data_flash_area_enable}, 2'h2);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000001, rd);
        bus(1'b1, `FCRC_OFS_PROC_MODE, 32'h00000000, rd);
        settle();
        chk(internal_area_expansion, 1'b1);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000000, rd);
        settle();
        chk(internal_area_expansion, 1'b0);
    endtask
    task automatic t_cmds();
        int n;
        int s0;
        // the bench is the rewrite software: no slow read, clock change, nmi, dma or flash fetch is modelled
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000001, rd);
        for (int c = 1; c <= 5; c++) begin
            s0 = n_starts;
            bus(1'b1, `FCRC_OFS_CTRL, 32'h00000009 | (c << 4), rd);
            settle();
            chk(n_starts - s0, 1);
            chk(cap_cmd, c[2:0]);
            chk(flash_ready_flag, 1'b0);
            // a second go while busy must be ignored
            bus(1'b1, `FCRC_OFS_CTRL, 32'h00000009 | (c << 4), rd);
            settle();
            chk(n_starts - s0, 1);
            @(posedge clk);
            flash_op_done  <= 1'b1;
            flash_op_error <= (c <= 2);
            n = 0;
            while (flash_ready_flag !== 1'b1 && n < 30) begin
                @(posedge clk);
                n++;
            end
            chk(n < 30, 1'b1);
            bus(1'b0, `FCRC_OFS_STATUS, 32'h0, rd);
            chk(rd[2:0], (c == 1) ? 3'h3 : (c == 2) ? 3'h5 : 3'h1);
            bus(1'b1, `FCRC_OFS_STATUS, 32'h00000006, rd);
            flash_op_done  <= 1'b0;
            flash_op_error <= 1'b0;
        end
    endtask
    // go refused with rewrite mode off or a code outside the set; option kept while busy
    task automatic t_refuse();
        int n;
        int s0;
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000000, rd);
        s0 = n_starts;
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000018, rd);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000001, rd);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000009, rd);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000079, rd);
        settle();
        chk(n_starts - s0, 0);
        chk(flash_ready_flag, 1'b1);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h0000001D, rd);
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000001, rd);
        bus(1'b0, `FCRC_OFS_CTRL, 32'h0, rd);
        chk(rd[6:0], 7'h15);
        chk(n_starts - s0, 1);
        @(posedge clk);
        flash_op_done <= 1'b1;
        n = 0;
        while (flash_ready_flag !== 1'b1 && n < 30) begin
            @(posedge clk);
            n++;
        end
        chk(n < 30, 1'b1);
        flash_op_done <= 1'b0;
        bus(1'b1, `FCRC_OFS_CTRL, 32'h00000000, rd);
        settle();
        chk(internal_area_expansion, 1'b0);
    endtask
    task automatic t_id();
        bus(1'b1, `FCRC_OFS_ID_KEY, ~ID_VAL, rd);
        settle();
        chk(debug_access_granted, 1'b0);
        bus(1'b1, `FCRC_OFS_ID_KEY, ID_VAL, rd);
        settle();
        chk(debug_access_granted, 1'b1);
        bus(1'b0, `FCRC_OFS_STATUS, 32'h0, rd);
        chk(rd[3:0], 4'h9);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_map();
        t_cmds();
        t_refuse();
        t_id();
        close_out();
    end
endmodule
